/* File: design/shp_serial_host_port.sv */
// Purpose: Serial host port: framed shift interface and two-wire slave
// Assumes: sclk_i is the host shift clock, idle either level
// Notes:   Shift logic runs on sclk_i; decode runs on ref_clk_i

`timescale 1ns/1ps

module shp_serial_host_port (
  input  wire logic                ref_clk_i,           // System clock
  input  wire logic                srst_i,              // Sync reset
  input  wire logic                sclk_i,              // Shift clock
  input  wire logic                frame_select_n_i,    // Frame, low
  input  wire logic                serial_in_i,         // Shift data in
  input  wire logic                chain_enable_i,      // Chain strap
  input  wire logic                interface_type_select_i,  // Strap
  input  wire logic                serial_protocol_select_i, // Strap
  input  wire logic                scl_i,               // Bus clock
  input  wire logic                sda_i,               // Bus data in
  input  wire logic                addr_strap_hi_i,     // Address bit
  input  wire logic                addr_strap_lo_i,     // Address bit
  input  wire logic [11:0]         rd_data_i,           // Readback data
  output logic                     chain_serial_out_o,  // Shift out
  output logic                     sda_o,               // Bus data out
  output logic                     sda_oe_o,            // Bus drive
  output logic                     cmd_valid_o,         // Write strobe
  output shp_pkg::shp_cmd_t        cmd_o,               // Write command
  output logic                     rd_req_o,            // Read strobe
  output shp_pkg::shp_rd_sel_t     rd_sel_o,            // Read target
  output logic                     bad_frame_o,         // Short frame
  output logic                     frame_active_o,      // Frame open
  output logic                     byte_valid_o,        // Bus byte
  output shp_pkg::shp_byte_t       byte_o               // Bus byte data
);
  import shp_pkg::*;

  // ---- Link side, clocked by the host shift clock ----

  logic                 new_frame_reg;
  logic                 launched_reg;
  logic                 sdo_reg;
  logic [1:0]           chain_sync_reg;
  logic [CMD_W-1:0]     sr_reg;
  logic [BIT_CNT_W-1:0] cnt_reg;

  // ---- System side ----

  logic                 fs_d_reg;
  shp_rd_sel_t          rd_sel_next;
  logic [CMD_W-1:0]     tx_word_reg;
  shp_cmd_t             held_cmd_reg;

  wire chain_mode = chain_sync_reg[1];
  wire fs_n       = frame_select_n_i;

  // Frame start marker: set while the frame is high, cleared by the
  // first falling shift edge. Preset by the frame, so it needs no reset.
  always_ff @(negedge sclk_i or posedge fs_n) begin
    if (fs_n) begin
      new_frame_reg <= 1'h1;
    end else begin
      new_frame_reg <= 1'h0;
    end
  end

  // Marks that a rising edge has launched a bit in this frame
  always_ff @(posedge sclk_i or posedge fs_n) begin
    if (fs_n) begin
      launched_reg <= 1'h0;
    end else begin
      launched_reg <= 1'h1;
    end
  end

  // Chain strap is static, but still crosses into this domain
  always_ff @(negedge sclk_i) begin
    chain_sync_reg <= {chain_sync_reg[0], chain_enable_i};
  end

  wire cnt_full = (cnt_reg == CMD_BITS);

  // Standalone stops after 24 bits; chain mode keeps shifting
  wire shift_en = ~fs_n & (new_frame_reg | chain_mode | ~cnt_full);

  wire [BIT_CNT_W-1:0] cnt_next =
    new_frame_reg ? BIT_CNT_W'(1) :
    cnt_full      ? cnt_reg       :
                    cnt_reg + BIT_CNT_W'(1);

  // The readback word is preloaded under the first bit, so it rides
  // out ahead of the incoming command on the serial output.
  wire [CMD_W-1:0] sr_next =
    new_frame_reg ? {tx_word_reg[CMD_W-2:0], serial_in_i} :
                    {sr_reg[CMD_W-2:0], serial_in_i};

  always_ff @(negedge sclk_i) begin
    if (shift_en) begin
      sr_reg  <= sr_next;
      cnt_reg <= cnt_next;
    end
  end

  // Bit launched on the rising edge is the one pushed out of the top
  always_ff @(posedge sclk_i) begin
    sdo_reg <= new_frame_reg ? tx_word_reg[CMD_W-1] :
                               sr_reg[CMD_W-1];
  end

  // Before the first rising edge the first readback bit is shown
  // straight away, so an idle-high clock still sees it at the fall.
  assign chain_serial_out_o = launched_reg ? sdo_reg :
                              tx_word_reg[CMD_W-1];

  // ---- System side: pin synchronisers ----

  // Frame level, mode straps and address straps all come from pins,
  // so each passes two flops before any decode reads it.
  localparam int PIN_N = 5;

  wire [PIN_N-1:0] pin_raw = {fs_n,
                              interface_type_select_i,
                              serial_protocol_select_i,
                              addr_strap_hi_i,
                              addr_strap_lo_i};
  wire [PIN_N-1:0] pin_s;

  for (genvar p = 0; p < PIN_N; p++) begin : g_pin_sync
    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
        meta_reg <= PIN_SYNC_RESET[p];
        sync_reg <= PIN_SYNC_RESET[p];
      end else begin
        meta_reg <= pin_raw[p];
        sync_reg <= meta_reg;
      end
    end

    assign pin_s[p] = sync_reg;
  end

  wire       fs_s      = pin_s[4];
  wire       type_s    = pin_s[3];
  wire       proto_s   = pin_s[2];
  wire [1:0] strap_s   = pin_s[1:0];
  wire       shift_sel = type_s & ~proto_s;
  wire       i2c_sel   = type_s & proto_s;
  wire       fs_rise   = fs_s & ~fs_d_reg;

  // Reset to the idle frame level, so reset release is not a rise
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      fs_d_reg <= 1'h1;
    end else begin
      fs_d_reg <= fs_s;
    end
  end

  // ---- Frame close and command decode ----

  // Shift register and count are frozen while the frame is high, so
  // they are read here as stable words once the rise has crossed.
  shp_cmd_t frame_cmd;
  assign frame_cmd = shp_cmd_t'(sr_reg);

  wire frame_good = fs_rise & shift_sel & cnt_full;
  wire frame_bad  = fs_rise & shift_sel & ~cnt_full;
  wire is_nop     = (sr_reg == NO_OP_WORD);
  wire is_read    = frame_cmd.direction_bit;
  wire do_write   = frame_good & ~is_read & ~is_nop;
  wire do_read    = frame_good & is_read;

  // Only address and register select matter for a read
  assign rd_sel_next = '{channel_addr:      frame_cmd.channel_addr,
                         target_reg_select: frame_cmd.target_reg_select};

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cmd_valid_o <= 1'h0;
      rd_req_o    <= 1'h0;
      bad_frame_o <= 1'h0;
    end else begin
      cmd_valid_o <= do_write;
      rd_req_o    <= do_read;
      bad_frame_o <= frame_bad;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cmd_o <= '0;
    end else if (do_write) begin
      cmd_o <= frame_cmd;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_sel_o     <= '0;
      held_cmd_reg <= '0;
    end else if (do_read) begin
      rd_sel_o     <= rd_sel_next;
      held_cmd_reg <= frame_cmd;
    end
  end

  // ---- Readback word for the following frame ----

  // The register answer is taken while rd_req_o is high, so the
  // target must reply in that same cycle.
  wire [HDR_W-1:0] echo_hdr = held_cmd_reg[CMD_W-1 -: HDR_W];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tx_word_reg <= TX_RESET;
    end else if (rd_req_o) begin
      tx_word_reg <= {echo_hdr, rd_data_i, TX_PAD};
    end else if (fs_rise) begin
      // Any other closed frame leaves nothing to read back
      tx_word_reg <= TX_RESET;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      frame_active_o <= 1'h0;
    end else begin
      frame_active_o <= ~fs_s & shift_sel;
    end
  end

  // ---- Two-wire slave ----

  shp_i2c_rx u_i2c_rx (
    .ref_clk_i    (ref_clk_i),
    .srst_i       (srst_i),
    .enable_i     (i2c_sel),
    .scl_i        (scl_i),
    .sda_i        (sda_i),
    .addr_strap_i (strap_s),
    .sda_o        (sda_o),
    .sda_oe_o     (sda_oe_o),
    .byte_o       (byte_o),
    .byte_valid_o (byte_valid_o)
  );

endmodule

/* File: design/shp_pkg.sv */
// Purpose: Shared types and constants of the serial host port
// Assumes: 24-bit shift commands, 12-bit channel words
// Notes:   Used by the port top and its two-wire receiver

package shp_pkg;

  // Shift command geometry
  localparam int          CMD_W      = 24;
  localparam int          WORD_W     = 12;
  localparam int          CHAN_W     = 6;
  localparam int          REGSEL_W   = 2;
  localparam int          BIT_CNT_W  = 5;
  localparam int          HDR_W      = 10;
  localparam logic [4:0]  CMD_BITS   = 5'h18;
  localparam logic [23:0] NO_OP_WORD = 24'h00_0000;
  localparam logic [23:0] TX_RESET   = 24'h00_0000;
  localparam logic [1:0]  TX_PAD     = 2'h0;

  // Pin synchroniser reset: frame idles high, straps low
  localparam logic [4:0]  PIN_SYNC_RESET = 5'h10;

  // Two-wire slave address and byte framing
  localparam logic [4:0]  SLAVE_ADDR_FIXED = 5'h15;
  localparam logic [3:0]  BYTE_BITS        = 4'h8;

  typedef struct packed {
    logic                bank_select;
    logic                direction_bit;
    logic [CHAN_W-1:0]   channel_addr;
    logic [REGSEL_W-1:0] target_reg_select;
    logic [WORD_W-1:0]   word_value;
    logic [1:0]          dont_care;
  } shp_cmd_t;

  typedef struct packed {
    logic [CHAN_W-1:0]   channel_addr;
    logic [REGSEL_W-1:0] target_reg_select;
  } shp_rd_sel_t;

  typedef struct packed {
    logic [7:0] data;
    logic       first;
  } shp_byte_t;

  typedef enum logic [3:0] {
    I2C_IDLE = 4'b0001,
    I2C_RECV = 4'b0010,
    I2C_ACK  = 4'b0100,
    I2C_SKIP = 4'b1000
  } shp_i2c_state_t;

endpackage

/* File: design/shp_i2c_rx.sv */
// Purpose: Receive-only two-wire slave for the serial host port
// Assumes: SCL and SDA oversampled by ref_clk_i, bus at most 400 kHz
// Notes:   Never drives SCL; SDA only pulled low for acknowledge

`timescale 1ns/1ps

module shp_i2c_rx (
  input  wire logic              ref_clk_i,    // System clock
  input  wire logic              srst_i,       // Synchronous reset
  input  wire logic              enable_i,     // Two-wire mode strapped
  input  wire logic              scl_i,        // Bus clock pin
  input  wire logic              sda_i,        // Bus data pin level
  input  wire logic [1:0]        addr_strap_i, // Low address bits
  output logic                   sda_o,        // Data drive value
  output logic                   sda_oe_o,     // Data drive enable
  output shp_pkg::shp_byte_t     byte_o,       // Received data byte
  output logic                   byte_valid_o  // Byte strobe
);
  import shp_pkg::*;

  logic [1:0]     scl_sync_reg;
  logic [1:0]     sda_sync_reg;
  logic           scl_d_reg;
  logic           sda_d_reg;
  shp_i2c_state_t state_reg;
  logic [3:0]     bit_cnt_reg;
  logic [7:0]     shift_reg;
  logic           addr_phase_reg;
  logic           first_reg;

  wire scl_s     = scl_sync_reg[1];
  wire sda_s     = sda_sync_reg[1];
  wire scl_rise  = scl_s & ~scl_d_reg;
  wire scl_fall  = ~scl_s & scl_d_reg;
  wire scl_high  = scl_s & scl_d_reg;
  wire start_det = scl_high & sda_d_reg & ~sda_s;
  wire stop_det  = scl_high & ~sda_d_reg & sda_s;
  wire byte_done = scl_fall & (bit_cnt_reg == BYTE_BITS);
  // Write-only device: a read request is not ours to answer
  wire addr_hit  = (shift_reg[7:1] == {SLAVE_ADDR_FIXED, addr_strap_i})
                   & ~shift_reg[0];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'h1;
      sda_d_reg    <= 1'h1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_d_reg    <= scl_s;
      sda_d_reg    <= sda_s;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    byte_valid_o <= 1'h0;
    sda_o        <= 1'h0;
    if (srst_i || !enable_i || stop_det) begin
      state_reg      <= I2C_IDLE;
      sda_oe_o       <= 1'h0;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      addr_phase_reg <= 1'h1;
      first_reg      <= 1'h0;
      byte_o         <= '0;
    end else if (start_det) begin
      // Repeated start simply restarts address reception
      state_reg      <= I2C_RECV;
      sda_oe_o       <= 1'h0;
      bit_cnt_reg    <= 4'h0;
      addr_phase_reg <= 1'h1;
    end else begin
      unique case (state_reg)
        I2C_IDLE, I2C_SKIP: begin
        end
        I2C_RECV: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_done && addr_phase_reg && !addr_hit) begin
            state_reg <= I2C_SKIP;
          end else if (byte_done) begin
            state_reg    <= I2C_ACK;
            sda_oe_o     <= 1'h1;
            byte_valid_o <= ~addr_phase_reg;
            byte_o       <= '{data: shift_reg, first: first_reg};
            first_reg    <= addr_phase_reg;
          end
        end
        I2C_ACK: begin
          // Held low over the whole ninth clock, released on its fall
          if (scl_fall) begin
            state_reg      <= I2C_RECV;
            sda_oe_o       <= 1'h0;
            bit_cnt_reg    <= 4'h0;
            addr_phase_reg <= 1'h0;
          end
        end
      endcase
    end
  end

endmodule

/* File: tb/shp_host_model.sv */
// Purpose: Host serial master model for shift link and two-wire bus
// Assumes: Shift clock idles high, 125 ns period; bus at 400 kHz
// Notes:   Data line toggles every half cycle for four cycles once released

`timescale 1ns/1ps

module shp_host_model (
  output logic      sclk_o,    // Shift clock
  output logic      frame_n_o, // Frame, active low
  output logic      sin_o,     // Shift data
  input  wire logic sdo_i,     // Chain serial out
  output logic      scl_o,     // Bus clock
  output logic      sda_m_o,   // Bus data, high releases
  input  wire logic sda_i      // Bus level
);
  localparam real HP = 62.5;
  localparam real Q  = 625.0;

  initial begin
    sclk_o    = 1'b1;
    frame_n_o = 1'b1;
    sin_o     = 1'b0;
    scl_o     = 1'b1;
    sda_m_o   = 1'b1;
  end

  task automatic frame(input logic [47:0] d, input int n,
                       output logic [47:0] c);
    c = '0;
    frame_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sin_o = d[i];
      #HP;
      c = {c[46:0], sdo_i};
      sclk_o = 1'b0;
      #HP;
      sclk_o = 1'b1;
    end
    #HP;
    frame_n_o = 1'b1;
    // Released data line toggles so a held value is never trusted
    repeat (8) begin
      sin_o = ~sin_o;
      #HP;
    end
  endtask

  // Clock pulses outside a frame, only when a test asks for them
  task automatic noise();
    repeat (5) begin
      sclk_o = 1'b0;
      sin_o = ~sin_o;
      #HP;
      sclk_o = 1'b1;
      #HP;
    end
  endtask

  task automatic i2c_start();
    sda_m_o = 1'b1;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_m_o = 1'b0;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask

  task automatic i2c_stop();
    sda_m_o = 1'b0;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_m_o = 1'b1;
    #Q;
  endtask

  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_m_o = b[i];
      #Q;
      scl_o = 1'b1;
      #(2.0 * Q);
      scl_o = 1'b0;
      #Q;
    end
    sda_m_o = 1'b1;
    #Q;
    scl_o = 1'b1;
    #Q;
    ack = ~sda_i;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask
endmodule

/* File: tb/shp_serial_host_port_asserts.sv */
// Purpose: Checker on serial host port outputs
// Assumes: Every watched output lives in the ref_clk_i domain
// Notes:   Bound from the bench top

`timescale 1ns/1ps

module shp_serial_host_port_asserts (
  input wire logic              ref_clk_i,                // Clock
  input wire logic              srst_i,                   // Reset
  input wire logic              interface_type_select_i,  // Strap
  input wire logic              serial_protocol_select_i, // Strap
  input wire logic              sda_o,                    // Bus data
  input wire logic              sda_oe_o,                 // Bus drive
  input wire logic              cmd_valid_o,              // Write
  input wire shp_pkg::shp_cmd_t cmd_o,                    // Command
  input wire logic              rd_req_o,                 // Read
  input wire logic              bad_frame_o,              // Short
  input wire logic              byte_valid_o              // Bus byte
);
  import shp_pkg::*;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  wire logic any_result = cmd_valid_o | rd_req_o | bad_frame_o;

  a_write_pulse : assert property (
    cmd_valid_o |=> !cmd_valid_o) else $error("write strobe too long");
  a_read_pulse : assert property (
    rd_req_o |=> !rd_req_o) else $error("read strobe too long");
  a_bad_alone : assert property (
    bad_frame_o |-> !cmd_valid_o && !rd_req_o)
    else $error("short frame executed");
  a_write_kind : assert property (
    cmd_valid_o |-> !cmd_o.direction_bit && cmd_o != NO_OP_WORD)
    else $error("read or empty word issued as write");
  a_shift_only : assert property (
    any_result |-> interface_type_select_i && !serial_protocol_select_i)
    else $error("shift result outside shift mode");
  a_ack_low : assert property (
    sda_oe_o |-> !sda_o) else $error("data line driven high");
  a_ack_mode : assert property (
    sda_oe_o |-> interface_type_select_i && serial_protocol_select_i)
    else $error("acknowledge outside two-wire mode");
  a_ack_holds : assert property (
    $rose(sda_oe_o) |-> sda_oe_o[*8]) else $error("acknowledge too short");
  a_byte_ack : assert property (
    byte_valid_o |-> ##[0:2] sda_oe_o) else $error("byte without ack");
  a_byte_pulse : assert property (
    byte_valid_o |=> !byte_valid_o) else $error("byte strobe too long");
endmodule

/* File: tb/test_serial_host_port.sv */
// Purpose: Self-checking bench of the serial host port
// Assumes: Host model drives shift link and bus; bench drives straps
// Notes:   Expected results queue up per frame or byte, in order

`timescale 1ns/1ps

module test_serial_host_port;
  import shp_pkg::*;

  logic        ref_clk_i, srst_i, sclk_i, frame_select_n_i, serial_in_i;
  logic        chain_enable_i, interface_type_select_i, sda_m, sda_i;
  logic        serial_protocol_select_i, scl_i, ack;
  logic        addr_strap_hi_i, addr_strap_lo_i;
  logic [11:0] rd_data_i;
  logic        chain_serial_out_o, sda_o, sda_oe_o, cmd_valid_o;
  logic        rd_req_o, bad_frame_o, frame_active_o, byte_valid_o;
  shp_cmd_t    cmd_o;
  shp_rd_sel_t rd_sel_o;
  shp_byte_t   byte_o;
  logic [47:0] cap;
  logic [23:0] w, r, ev;
  logic        ea;
  logic [23:0] vq[$];
  int          kq[$];
  int          k;
  int          n_errors = 0;
  int          num_checks = 0;
  integer      seed = 59397;

  // Open-drain data line with pull-up
  assign sda_i = sda_m & ~(sda_oe_o & ~sda_o);

  shp_serial_host_port dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .sclk_i(sclk_i),
    .frame_select_n_i(frame_select_n_i), .serial_in_i(serial_in_i),
    .chain_enable_i(chain_enable_i),
    .interface_type_select_i(interface_type_select_i),
    .serial_protocol_select_i(serial_protocol_select_i),
    .scl_i(scl_i), .sda_i(sda_i), .addr_strap_hi_i(addr_strap_hi_i),
    .addr_strap_lo_i(addr_strap_lo_i), .rd_data_i(rd_data_i),
    .chain_serial_out_o(chain_serial_out_o), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o),
    .rd_req_o(rd_req_o), .rd_sel_o(rd_sel_o), .bad_frame_o(bad_frame_o),
    .frame_active_o(frame_active_o), .byte_valid_o(byte_valid_o),
    .byte_o(byte_o));

  shp_host_model host (
    .sclk_o(sclk_i), .frame_n_o(frame_select_n_i), .sin_o(serial_in_i),
    .sdo_i(chain_serial_out_o), .scl_o(scl_i), .sda_m_o(sda_m),
    .sda_i(sda_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic push(input int k0, input logic [23:0] v);
    kq.push_back(k0);
    vq.push_back(v);
  endtask

  // Model: first 24 bits standalone, last 24 in chain; short is bad
  task automatic send(input logic [47:0] d, input int n);
    logic [23:0] x;
    x = chain_enable_i ? d[23:0] : 24'(d >> (n - 24));
    if (!serial_protocol_select_i) begin
      if (n < 24) push(3, 24'h00_0000);
      else if (x != NO_OP_WORD) push(x[22] ? 2 : 1, x);
    end
    host.frame(d, n, cap);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(negedge ref_clk_i) begin
    if ((cmd_valid_o | rd_req_o | bad_frame_o | byte_valid_o) === 1'b1) begin
      k = cmd_valid_o ? 1 : rd_req_o ? 2 : bad_frame_o ? 3 : 4;
      if (kq.size() == 0) push(0, 24'h00_0000);
      check(k == kq.pop_front(), "unexpected result kind");
      ev = vq.pop_front();
      if (k == 1) check(cmd_o[23:2] === ev[23:2], "write word");
      if (k == 2) check(rd_sel_o === ev[21:14], "read select");
      if (k == 4) check(byte_o === ev[8:0], "bus byte");
    end
  end

  // Mid-frame, the synced frame level shows in shift mode only
  always @(negedge sclk_i) begin
    if (frame_select_n_i === 1'b0) begin
      ea = interface_type_select_i & ~serial_protocol_select_i;
      check(frame_active_o === ea, "frame active");
    end
  end

  initial begin
    #700000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    srst_i = 1'b1;
    chain_enable_i = 1'b0;
    interface_type_select_i = 1'b1;
    serial_protocol_select_i = 1'b0;
    {addr_strap_hi_i, addr_strap_lo_i} = 2'b00;
    rd_data_i = 12'h000;
    repeat (4) @(negedge ref_clk_i);
    srst_i = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    repeat (4) begin
      w = {2'b00, 22'($random(seed))} | 24'h00_0004;
      send({24'h00_0000, w}, 24);
    end
    $display("test writes done");
    @(negedge ref_clk_i);
    rd_data_i = 12'($random(seed));
    w = {2'b01, 22'($random(seed))};
    send({24'h00_0000, w}, 24);
    send(48'h0000_0000_0000, 24);
    check(cap[23:0] === {w[23:14], rd_data_i, 2'b00}, "readback");
    $display("test readback done");
    send({24'h00_0000, w}, 23);
    w = {2'b00, 22'($random(seed))} | 24'h00_0004;
    send({18'h0_0000, w, 6'h2a}, 30);
    host.noise();
    send({24'h00_0000, w ^ 24'h00_0ff0}, 24);
    $display("test framing done");
    @(negedge ref_clk_i);
    chain_enable_i = 1'b1;
    r = {2'b00, 22'($random(seed))} | 24'h00_0004;
    send({r, w}, 48);
    check(cap[23:0] === r, "chain output");
    $display("test chain done");
    @(negedge ref_clk_i);
    chain_enable_i = 1'b0;
    serial_protocol_select_i = 1'b1;
    send({24'h00_0000, w}, 24);
    for (int s = 0; s < 4; s++) begin
      @(negedge ref_clk_i);
      {addr_strap_hi_i, addr_strap_lo_i} = 2'(s);
      w = 24'($random(seed));
      host.i2c_start();
      host.i2c_byte({SLAVE_ADDR_FIXED, 2'(s), 1'b0}, ack);
      check(ack === 1'b1, "address ack");
      push(4, {15'h0000, w[7:0], 1'b1});
      host.i2c_byte(w[7:0], ack);
      check(ack === 1'b1, "data ack");
      push(4, {15'h0000, w[15:8], 1'b0});
      host.i2c_byte(w[15:8], ack);
      host.i2c_start();
      host.i2c_byte(s[0] ? {SLAVE_ADDR_FIXED, 2'(s), 1'b1}
                         : {SLAVE_ADDR_FIXED, 2'(s) ^ 2'b01, 1'b0}, ack);
      check(ack === 1'b0, "foreign or read address");
      host.i2c_start();
      host.i2c_byte({SLAVE_ADDR_FIXED, 2'(s), 1'b0}, ack);
      check(ack === 1'b1, "retried address");
      host.i2c_stop();
    end
    check(kq.size() == 0, "missing result");
    $display("test two-wire done");
    end_of_test();
  end
endmodule

bind shp_serial_host_port shp_serial_host_port_asserts u_chk (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i),
  .interface_type_select_i(interface_type_select_i),
  .serial_protocol_select_i(serial_protocol_select_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .cmd_valid_o(cmd_valid_o),
  .cmd_o(cmd_o), .rd_req_o(rd_req_o), .bad_frame_o(bad_frame_o),
  .byte_valid_o(byte_valid_o));
